// file: src/bbsw_pkg.sv
package bbsw_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int unsigned BBSW_ADDR_W       = 12;
  localparam logic [11:0] BBSW_CTRL_OFFS    = 12'h000;
  localparam logic [11:0] BBSW_STATUS_OFFS  = 12'h004;

  // Control word fields.
  localparam int unsigned BBSW_CTRL_SWAP_BIT = 0;
  localparam int unsigned BBSW_CTRL_LOCK_BIT = 1;

  // Status word fields.
  localparam int unsigned BBSW_STS_SWAP_BIT   = 0;
  localparam int unsigned BBSW_STS_STRAP_BIT  = 1;
  localparam int unsigned BBSW_STS_SIZE_LSB   = 2;
  localparam int unsigned BBSW_STS_LOCK_BIT   = 5;
  localparam int unsigned BBSW_STS_BWRST_BIT  = 6;
  localparam int unsigned BBSW_STS_PLRST_BIT  = 7;

  // Reset values.
  localparam logic        BBSW_SWAP_RST     = 1'b0;
  localparam logic        BBSW_LOCK_RST     = 1'b0;
  localparam logic [31:0] BBSW_RDATA_RST    = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Remap geometry
  // ---------------------------------------------------------------------
  localparam int unsigned BBSW_CYC_ADDR_W   = 32;
  localparam int unsigned BBSW_SIZE_W       = 3;
  localparam logic [4:0]  BBSW_BASE_BIT     = 5'h10;
  localparam logic [31:0] BBSW_ONES         = 32'hffff_ffff;
  localparam logic [31:0] BBSW_ONE          = 32'h0000_0001;

  // ---------------------------------------------------------------------
  // Pin synchroniser layout
  // ---------------------------------------------------------------------
  localparam int unsigned BBSW_SYNC_W       = 6;
  localparam int unsigned BBSW_SY_BWRST     = 0;
  localparam int unsigned BBSW_SY_PLRST     = 1;
  localparam int unsigned BBSW_SY_STRAP     = 2;
  localparam int unsigned BBSW_SY_SIZE_LSB  = 3;
  // Reset lines idle high, straps idle low.
  localparam logic [5:0]  BBSW_SYNC_RST     = 6'h03;

  // ---------------------------------------------------------------------
  // Host cycle carrier
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic        to_flash;
    logic        write;
  } bbsw_cyc_t;

  localparam bbsw_cyc_t BBSW_CYC_RST = '{addr: 32'h0000_0000,
                                         to_flash: 1'b0,
                                         write: 1'b0};

endpackage

// file: src/bbsw_remap.sv
`timescale 1ns/1ns
module bbsw_remap
  import bbsw_pkg::*;
(
  // Incoming cycle
  input  wire bbsw_cyc_t          cyc_i,
  // Swap control
  input  wire logic               swap_en_i,
  input  wire logic [2:0]         size_code_i,
  // Remapped cycle
  output      bbsw_cyc_t          cyc_o,
  output      logic               flipped_o
);

  // ---------------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------------
  // Inverted bit sits at 16 plus the size code.
  wire logic [4:0]  flip_pos;
  wire logic [4:0]  top_pos;
  wire logic [31:0] region_mask;
  wire logic [31:0] flip_mask;
  wire logic        in_top;

  assign flip_pos    = BBSW_BASE_BIT + {2'b00, size_code_i}; // R17
  assign top_pos     = flip_pos + 5'h01;
  // The two exchanged blocks share every bit above the flipped one.
  assign region_mask = BBSW_ONES << top_pos;
  assign flip_mask   = BBSW_ONE << flip_pos;                  // R1
  assign in_top      = (cyc_i.addr & region_mask) == region_mask;

  // ---------------------------------------------------------------------
  // Address output
  // ---------------------------------------------------------------------
  // R3 R4 R5 R6 R7 R8 R9 R10
  assign flipped_o = swap_en_i & cyc_i.to_flash & in_top;    // R14
  assign cyc_o.addr     = flipped_o ? (cyc_i.addr ^ flip_mask)
                                    : cyc_i.addr;            // R2
  assign cyc_o.to_flash = cyc_i.to_flash;
  assign cyc_o.write    = cyc_i.write;

endmodule

// file: src/bbsw_top.sv
// What this block does
// R1: While swap is on, invert one address line on flash cycles in the top region.
// R2: While swap is off, flash addresses pass unchanged, no bit inverted.
// R3: Size 000: FFFF_0000-FFFF_FFFF exchanges with FFFE_0000-FFFE_FFFF.
// R4: Size 001: FFFE_0000-FFFF_FFFF exchanges with FFFC_0000-FFFD_FFFF.
// R5: Size 010: FFFC_0000-FFFF_FFFF exchanges with FFF8_0000-FFFB_FFFF.
// R6: Size 011: FFF8_0000-FFFF_FFFF exchanges with FFF0_0000-FFF7_FFFF.
// R7: Size 100: FFF0_0000-FFFF_FFFF exchanges with FFE0_0000-FFEF_FFFF.
// R8: Size 101: FFE0_0000-FFFF_FFFF exchanges with FFC0_0000-FFDF_FFFF.
// R9: Size 110: FFC0_0000-FFFF_FFFF exchanges with FF80_0000-FFBF_FFFF.
// R10: Size 111: FF80_0000-FFFF_FFFF exchanges with FF00_0000-FF7F_FFFF.
// R11: Battery-well reset clears the swap bit; platform reset leaves it alone.
// R12: Swap bit lives in the battery-backed well and survives power loss.
// R13: Forcing strap makes swap read and act as 1; software cannot clear it.
// R14: Only cycles aimed at the serial flash are remapped.
// R15: Software copies, verifies, swaps, erases, rewrites, verifies, unswaps, locks.
// R16: Software should checksum the copied block before enabling swap.
// R17: Inverted bit is 16 plus the block-size code.
// R18: With lock-down set, swap writes are ignored until a reset clears lock.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module bbsw_top
  import bbsw_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  // Pins from the platform
  input  wire logic                   battery_well_reset_n_i,
  input  wire logic                   platform_reset_n_i,
  input  wire logic                   swap_force_strap_i,
  input  wire logic [2:0]             block_size_strap_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [BBSW_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output      logic [31:0]            prdata_o,
  output      logic                   pready_o,
  output      logic                   pslverr_o,
  // Host cycles in
  input  wire logic                   up_valid_i,
  input  wire bbsw_cyc_t              up_cyc_i,
  // Cycles to the flash controller and other targets
  output      logic                   dn_valid_o,
  output      bbsw_cyc_t              dn_cyc_o,
  output      logic                   dn_flipped_o,
  // State
  output      logic                   swap_active_o
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // Straps are static in normal use; a strap that moves mid-run may show
  // a mixed size code for one cycle, which only a misused jumper causes.
  wire logic [BBSW_SYNC_W-1:0] pins_raw;
  wire logic [BBSW_SYNC_W-1:0] pins_sync;

  assign pins_raw = {block_size_strap_i,
                     swap_force_strap_i,
                     platform_reset_n_i,
                     battery_well_reset_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < BBSW_SYNC_W; gi++)
    begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          meta_reg <= BBSW_SYNC_RST[gi];
          sync_reg <= BBSW_SYNC_RST[gi];
        end
        else
        begin
          meta_reg <= pins_raw[gi];
          sync_reg <= meta_reg;
        end
      end
      assign pins_sync[gi] = sync_reg;
    end
  endgenerate

  wire logic       bw_rst_act;
  wire logic       pl_rst_act;
  wire logic       strap_act;
  wire logic [2:0] size_code;

  assign bw_rst_act = ~pins_sync[BBSW_SY_BWRST];
  assign pl_rst_act = ~pins_sync[BBSW_SY_PLRST];
  assign strap_act  = pins_sync[BBSW_SY_STRAP];
  // The size code is not latched: every cycle uses the live synchronised
  // strap, so moving the strap mid-run retargets the swap at once.
  assign size_code  = pins_sync[BBSW_SY_SIZE_LSB +: BBSW_SIZE_W];

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  function automatic logic hit_offs(input logic [BBSW_ADDR_W-1:0] a,
                                    input logic [BBSW_ADDR_W-1:0] o);
    hit_offs = (a == o);
  endfunction

  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  wire logic setup_ph;
  wire logic access_ok;
  wire logic sel_ctrl;
  wire logic sel_status;
  wire logic mapped;
  wire logic wr_ctrl;
  wire logic wr_lane0;

  assign setup_ph   = psel_i & ~penable_i;
  assign access_ok  = psel_i & penable_i & pready_reg;
  assign sel_ctrl   = hit_offs(paddr_i, BBSW_CTRL_OFFS);
  assign sel_status = hit_offs(paddr_i, BBSW_STATUS_OFFS);
  assign mapped     = sel_ctrl | sel_status;
  // Status is read-only, so a write there is refused like a hole.
  assign wr_ctrl    = access_ok & pwrite_i & sel_ctrl;
  // Only byte lane 0 carries fields, so a write with pstrb_i[0] low
  // changes nothing; the upper strobes are accepted and ignored.
  assign wr_lane0   = wr_ctrl & pstrb_i[0];

  // ---------------------------------------------------------------------
  // Swap and lock-down state
  // ---------------------------------------------------------------------
  // The swap flop stands for the battery-backed bit: only the power-on
  // reset and the battery-well reset touch it, never the platform reset.
  logic swap_reg;
  logic swap_next;
  logic lock_reg;
  logic lock_next;
  logic bw_seen_reg;
  logic bw_seen_next;
  logic pl_seen_reg;
  logic pl_seen_next;

  wire logic swap_wr_ok;
  wire logic swap_eff;

  // R18: lock blocks the write; R13: strap blocks it too.
  assign swap_wr_ok = wr_lane0 & ~lock_reg & ~strap_act;     // R18 R13
  assign swap_eff   = swap_reg | strap_act;                  // R13

  always_comb
  begin
    swap_next = swap_reg;
    if (bw_rst_act)
      swap_next = 1'b0;                                      // R11
    else if (swap_wr_ok)
      swap_next = pwdata_i[BBSW_CTRL_SWAP_BIT];
  end

  always_comb
  begin
    lock_next = lock_reg;
    if (bw_rst_act | pl_rst_act)
      lock_next = 1'b0;                                      // R18
    else if (wr_lane0 & pwdata_i[BBSW_CTRL_LOCK_BIT])
      lock_next = 1'b1;
  end

  // Sticky reset-seen flags; a new reset event wins over a clear write.
  // Both are cleared through the control word, since the status word is
  // read-only; software learns from them which resets have hit since the last clear.
  always_comb
  begin
    bw_seen_next = bw_seen_reg;
    pl_seen_next = pl_seen_reg;
    if (wr_lane0)
    begin
      if (pwdata_i[BBSW_STS_BWRST_BIT])
        bw_seen_next = 1'b0;
      if (pwdata_i[BBSW_STS_PLRST_BIT])
        pl_seen_next = 1'b0;
    end
    if (bw_rst_act)
      bw_seen_next = 1'b1;
    if (pl_rst_act)
      pl_seen_next = 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      swap_reg    <= BBSW_SWAP_RST;                          // R12
      lock_reg    <= BBSW_LOCK_RST;
      bw_seen_reg <= 1'b0;
      pl_seen_reg <= 1'b0;
    end
    else
    begin
      swap_reg    <= swap_next;                              // R12
      lock_reg    <= lock_next;
      bw_seen_reg <= bw_seen_next;
      pl_seen_reg <= pl_seen_next;
    end
  end

  // ---------------------------------------------------------------------
  // APB read data and answer
  // ---------------------------------------------------------------------
  // The answer is prepared in the setup cycle so that the access phase
  // always completes in one cycle with registered outputs.
  wire logic [31:0] ctrl_word;
  wire logic [31:0] status_word;

  assign ctrl_word   = {30'h0000_0000, lock_reg, swap_eff};  // R13
  assign status_word = {24'h00_0000,
                        pl_seen_reg,
                        bw_seen_reg,
                        lock_reg,
                        size_code,
                        strap_act,
                        swap_eff};

  // Read data is zero outside an access, so a stale word never lingers
  // on the bus between transfers.
  always_comb
  begin
    prdata_next = BBSW_RDATA_RST;
    if (setup_ph & ~pwrite_i & sel_ctrl)
      prdata_next = ctrl_word;
    else if (setup_ph & ~pwrite_i & sel_status)
      prdata_next = status_word;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= BBSW_RDATA_RST;
    end
    else
    begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & (~mapped | (pwrite_i & sel_status));
      prdata_reg  <= prdata_next;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;

  // ---------------------------------------------------------------------
  // Cycle remap path
  // ---------------------------------------------------------------------
  bbsw_cyc_t remap_cyc;
  logic      remap_flip;

  bbsw_remap u_remap
  (
    .cyc_i       (up_cyc_i),
    .swap_en_i   (swap_eff),
    .size_code_i (size_code),
    .cyc_o       (remap_cyc),
    .flipped_o   (remap_flip)
  );

  logic      dn_valid_reg;
  bbsw_cyc_t dn_cyc_reg;
  logic      dn_flip_reg;
  logic      swap_out_reg;

  // One register stage; non-flash cycles go through untouched.
  // The stage costs one cycle of latency on every host cycle, but keeps
  // the flash-bound address free of decode glitches and lets every
  // output come straight from a flop.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      dn_valid_reg <= 1'b0;
      dn_cyc_reg   <= BBSW_CYC_RST;
      dn_flip_reg  <= 1'b0;
      swap_out_reg <= 1'b0;
    end
    else
    begin
      dn_valid_reg <= up_valid_i;
      dn_cyc_reg   <= remap_cyc;                             // R14 R1
      dn_flip_reg  <= up_valid_i & remap_flip;
      swap_out_reg <= swap_eff;
    end
  end

  assign dn_valid_o    = dn_valid_reg;
  assign dn_cyc_o      = dn_cyc_reg;
  assign dn_flipped_o  = dn_flip_reg;
  assign swap_active_o = swap_out_reg;

endmodule

// file: tb/bbsw_top_properties.sv
`timescale 1ns/1ns
module bbsw_top_properties
  import bbsw_pkg::*;
(
  // Clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  // Pins
  input wire logic                   battery_well_reset_n_i,
  input wire logic                   swap_force_strap_i,
  input wire logic [2:0]             block_size_strap_i,
  // APB
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic [BBSW_ADDR_W-1:0] paddr_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  // Cycle path
  input wire logic                   up_valid_i,
  input wire bbsw_cyc_t              up_cyc_i,
  input wire logic                   dn_valid_o,
  input wire bbsw_cyc_t              dn_cyc_o,
  input wire logic                   dn_flipped_o,
  input wire logic                   swap_active_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_strap;
    swap_force_strap_i [*5];
  endsequence
  sequence s_bw;
    (!battery_well_reset_n_i && !swap_force_strap_i) [*5];
  endsequence
  // A flash cycle inside the two exchanged blocks of the settled size.
  sequence s_flash_top;
    up_valid_i && up_cyc_i.to_flash
      && block_size_strap_i == $past(block_size_strap_i, 3)
      && block_size_strap_i == $past(block_size_strap_i, 2)
      && (up_cyc_i.addr & (BBSW_ONES << (17 + block_size_strap_i)))
        == (BBSW_ONES << (17 + block_size_strap_i));
  endsequence

  property p_rdy;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err;
    psel_i && !penable_i && paddr_i != 12'h000 && paddr_i != 12'h004
      |=> pslverr_o;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_vld;
    dn_valid_o == $past(up_valid_i);
  endproperty
  a_vld: assert property (p_vld) else $error("cycle valid not one late");
  property p_fld;
    up_valid_i |=> dn_cyc_o.to_flash == $past(up_cyc_i.to_flash)
      && dn_cyc_o.write == $past(up_cyc_i.write);
  endproperty
  a_fld: assert property (p_fld) else $error("cycle kind altered");
  property p_nf;
    up_valid_i && !up_cyc_i.to_flash
      |=> dn_cyc_o.addr == $past(up_cyc_i.addr) && !dn_flipped_o;
  endproperty
  a_nf: assert property (p_nf) else $error("non-flash cycle altered");
  // The swap state output lags by one cycle, so the value it shows one
  // cycle after the request is the one the remap used for it.
  property p_off;
    up_valid_i && up_cyc_i.to_flash ##1 !swap_active_o
      |-> dn_cyc_o.addr == $past(up_cyc_i.addr) && !dn_flipped_o;
  endproperty
  a_off: assert property (p_off) else $error("address altered, swap off");
  property p_on;
    s_flash_top ##1 swap_active_o
      |-> dn_flipped_o && dn_cyc_o.addr == ($past(up_cyc_i.addr)
        ^ (BBSW_ONE << (16 + $past(block_size_strap_i))));
  endproperty
  a_on: assert property (p_on) else $error("wrong bit inverted");
  property p_strap;
    s_strap |-> swap_active_o;
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not force");
  property p_bw;
    s_bw |-> !swap_active_o;
  endproperty
  a_bw: assert property (p_bw) else $error("well reset kept swap");
endmodule

bind bbsw_top bbsw_top_properties i_props (.clk_sys_i, .rst_n_i,
  .battery_well_reset_n_i, .swap_force_strap_i, .block_size_strap_i,
  .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .up_valid_i,
  .up_cyc_i, .dn_valid_o, .dn_cyc_o, .dn_flipped_o, .swap_active_o);

// file: tb/bbsw_host_flash_model.sv
`timescale 1ns/1ns
module bbsw_host_flash_model
  import bbsw_pkg::*;
(
  // Clock
  input  wire logic      clk_sys_i,
  // Host side
  output      logic      up_valid_o,
  output      bbsw_cyc_t up_cyc_o,
  // Flash controller side
  input  wire logic      dn_valid_i,
  input  wire bbsw_cyc_t dn_cyc_i,
  input  wire logic      dn_flipped_i
);
  initial
  begin
    up_valid_o = 1'b0;
    up_cyc_o = BBSW_CYC_RST;
  end

  // One fetch; the address is inverted once released so stale data shows.
  // Non-flash cycles go out as writes so the two kind bits differ.
  task automatic fetch(input logic [31:0] ad, input logic fl,
                       output logic [31:0] ga, output logic gf,
                       output logic gv);
    up_valid_o <= 1'b1;
    up_cyc_o <= '{addr: ad, to_flash: fl, write: ~fl};
    @(posedge clk_sys_i);
    up_valid_o <= 1'b0;
    up_cyc_o.addr <= ~ad;
    @(negedge clk_sys_i);
    ga = dn_cyc_i.addr;
    gf = dn_flipped_i;
    gv = dn_valid_i;
    @(posedge clk_sys_i);
  endtask
endmodule

// file: tb/bbsw_top_tb_top.sv
`timescale 1ns/1ns
module bbsw_top_tb_top
  import bbsw_pkg::*;
;
  logic        clk_sys_i, rst_n_i, battery_well_reset_n_i, platform_reset_n_i;
  logic        swap_force_strap_i, psel_i, penable_i, pwrite_i;
  logic [2:0]  block_size_strap_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, ga, a;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, up_valid_i, dn_valid_o, dn_flipped_o;
  logic        swap_active_o, er, gf, gv;
  bbsw_cyc_t   up_cyc_i, dn_cyc_o;
  int          n_fail, n_checks, cyc;

  bbsw_top i_dut (.clk_sys_i, .rst_n_i, .battery_well_reset_n_i,
    .platform_reset_n_i, .swap_force_strap_i, .block_size_strap_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .up_valid_i, .up_cyc_i, .dn_valid_o, .dn_cyc_o,
    .dn_flipped_o, .swap_active_o);
  bbsw_host_flash_model i_pm (.clk_sys_i(clk_sys_i), .up_valid_o(up_valid_i),
    .up_cyc_o(up_cyc_i), .dn_valid_i(dn_valid_o), .dn_cyc_i(dn_cyc_o),
    .dn_flipped_i(dn_flipped_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole run is a few hundred cycles; the ceiling leaves wide margin.
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] gt);
    n_checks++;
    if (gt !== ex)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1)
      @(posedge clk_sys_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic pin_pulse(input int which);
    if (which == 0)
      platform_reset_n_i <= 1'b0;
    else
      battery_well_reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    platform_reset_n_i <= 1'b1;
    battery_well_reset_n_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
  endtask

  initial
  begin
    {rst_n_i, psel_i, penable_i, pwrite_i, swap_force_strap_i} = '0;
    {battery_well_reset_n_i, platform_reset_n_i} = 2'b11;
    {block_size_strap_i, paddr_i, pwdata_i, cyc} = '0;
    pstrb_i = 4'hf;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    for (int sw = 0; sw < 2; sw++)
    begin
      apb(1'b1, 12'h000, sw);
      for (int c = 0; c < 8; c++)
      begin
        block_size_strap_i <= c[2:0];
        repeat (4) @(posedge clk_sys_i);
        a = (sw == 1) ? (32'h0001_0000 << c) : 32'h0;
        i_pm.fetch(32'hffff_0000, 1'b1, ga, gf, gv);
        chk("top", 32'hffff_0000 ^ a, ga);
        chk("flip", {31'h0, a != 0}, {31'h0, gf});
        chk("valid", 32'h1, {31'h0, gv});
        i_pm.fetch(32'hffff_0000 ^ a, 1'b1, ga, gf, gv);
        chk("lower", 32'hffff_0000, ga);
        i_pm.fetch(32'hffff_0000 - (a << 1), 1'b1, ga, gf, gv);
        chk("below", 32'hffff_0000 - (a << 1), ga);
        i_pm.fetch(32'hffff_0000, 1'b0, ga, gf, gv);
        chk("other", 32'hffff_0000, ga);
      end
    end
    // Update order: swap set above, now cleared and then locked.
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("locked", 32'h2, rd);
    pin_pulse(0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("unlocked", 32'h1, rd);
    pin_pulse(0);
    apb(1'b0, 12'h000, 32'h0);
    chk("plt kept", 32'h1, rd);
    pin_pulse(1);
    apb(1'b0, 12'h000, 32'h0);
    chk("well clr", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h0000_00dc, rd);
    apb(1'b1, 12'h000, 32'h0000_00c0);
    apb(1'b0, 12'h004, 32'h0);
    chk("seen clr", 32'h0000_001c, rd);
    swap_force_strap_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("forced", 32'h1, rd & 32'h1);
    swap_force_strap_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    apb(1'b0, 12'h000, 32'h0);
    chk("unforced", 32'h0, rd & 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 12'h004, 32'hff);
    chk("ro write", 32'h1, {31'h0, er});
    complete_run();
  end
endmodule
